// ===== sim/sirp_chk.sv
/*
 * Checker of the two-wire link between controller and sensor target.
 * Assumes it stands beside the interface, on the system clock domain.
 */
`timescale 1ns/10ps
module sirp_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ctl_sda_oe,
  input wire logic tgt_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic unlocked
);
  // All checks on the system clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Lines released after reset
  a_idle_after_rst: assert property (
    $rose(reset_n) |-> scl && sda && !tgt_sda_oe)
    else $error("bus not idle after reset");
  // Start always made by the controller
  a_start_by_ctl: assert property (
    scl && $past(scl) && $fell(sda) |-> ctl_sda_oe && !tgt_sda_oe)
    else $error("start not made by controller");
  // Target starts or ends its pull on the data line only while the clock is low
  a_drive_scl_low: assert property (
    $rose(tgt_sda_oe) |-> !scl)
    else $error("target drives data with clock high");
  a_free_scl_low: assert property (
    $fell(tgt_sda_oe) |-> !scl)
    else $error("target releases data with clock high");
  a_steady_scl_hi: assert property (
    scl && $past(scl) |-> $stable(tgt_sda_oe))
    else $error("target data moves while clock high");
  // Both ends never pull together while the clock is high; a short
  // overlap of two low pulls with the clock low is harmless
  a_no_contention: assert property (
    tgt_sda_oe && scl |-> !ctl_sda_oe)
    else $error("both ends drive data");
  // A driven bit covers the next clock rise
  a_ack_over_clk: assert property (
    $rose(tgt_sda_oe) |-> tgt_sda_oe throughout ##[1:40] $rose(scl))
    else $error("target bit not held over clock rise");
  // Target silent after stop
  a_quiet_at_stop: assert property (
    scl && $rose(sda) |-> ##1 !tgt_sda_oe [*8])
    else $error("target drives after stop");
  a_lock_sticky: assert property (
    unlocked |=> unlocked)
    else $error("write lock returned");
endmodule : sirp_chk

// ===== sim/tb_sensor_i2c_register_port.sv
/*
 * Bench joining controller and target over the two-wire interface.
 * Assumes AXI4-Lite access to the controller registers, short SCL.
 */
`timescale 1ns/10ps
module tb_sensor_i2c_register_port;
  import sirp_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, unlocked;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] sleep_word, st, d;
  logic [63:0] mon = 64'h0;
  logic        pscl = 1'b1, psda = 1'b1;
  int          nbit = 0;
  int          error_cnt = 0;
  int          n_checks = 0;
  localparam logic [7:0] WA = {SIRP_DEV_ADDR, 1'b0};
  localparam logic [7:0] RA = {SIRP_DEV_ADDR, 1'b1};

  sirp_if u_sirp_if ();
  sirp_ctrl #(.QTR(8)) u_sirp_ctrl (.clk(clk), .reset_n(reset_n),
    .bus(u_sirp_if.ctl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  sirp_target u_sirp_target (.clk(clk), .reset_n(reset_n),
    .bus(u_sirp_if.tgt), .unlocked(unlocked), .sleep_word(sleep_word));
  sirp_chk u_sirp_chk (.clk(clk), .reset_n(reset_n),
    .ctl_sda_oe(u_sirp_if.ctl_sda_oe), .tgt_sda_oe(u_sirp_if.tgt_sda_oe),
    .scl(u_sirp_if.scl), .sda(u_sirp_if.sda), .unlocked(unlocked));

  // System clock
  always #5 clk = ~clk;

  // Wire monitor: bits at clock rise, count cleared by start;
  // the clock pulse of a stop shifts in one extra low bit
  always @(posedge clk) begin
    pscl <= u_sirp_if.scl;
    psda <= u_sirp_if.sda;
    if (pscl && u_sirp_if.scl && psda && !u_sirp_if.sda) begin
      nbit <= 0;
    end else if (!pscl && u_sirp_if.scl) begin
      mon  <= {mon[62:0], u_sirp_if.sda};
      nbit <= nbit + 1;
    end
  end

  // Byte and acknowledge frame as seen on the wire
  function automatic logic [63:0] frm(logic [7:0] a, logic [31:0] v,
                                      logic last);
    frm = {19'h0, a, 1'b0, v[31:24], 1'b0, v[23:16], 1'b0, v[15:8],
           1'b0, v[7:0], last};
  endfunction : frm

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic hang;
    error_cnt++;
    $display("wait limit reached at %0t", $time);
    stop_test();
  endtask : hang

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // AXI write: address and data together, response after both
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
    bit ta, tw, tb;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axw

  // AXI read
  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
    bit ta, tb;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tb = rvalid;
      v  = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tb) begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axr

  // One serial command through the controller, polled to completion
  task automatic cmd(input logic [6:0] dv, input logic [7:0] rg,
                     input logic rd, input logic [31:0] v);
    logic [1:0] rs;
    axw(SIRP_WDATA_OFS, v, rs);
    axw(SIRP_CTRL_OFS, {1'b1, 14'h0, rd, rg, 1'b0, dv}, rs);
    for (int i = 0; i < 3000; i++) begin
      axr(SIRP_STAT_OFS, st, rs);
      if (st[SIRP_STAT_BUSY] === 1'b0) begin
        if (rd) axr(SIRP_RDATA_OFS, d, rs);
        return;
      end
    end
    hang();
  endtask : cmd

  task automatic rst;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rst

  // Main sequence
  initial begin
    rst();
    chk(64'(unlocked), 64'h0);
    cmd(SIRP_DEV_ADDR, 8'h03, 1'b0, 32'hA5A55A5A);
    chk(64'(st[SIRP_STAT_NACK]), 64'h0);
    chk(64'(mon[54:46]), 64'({WA, 1'b0}));
    chk(64'(mon[45:1]), frm(8'h03, 32'hA5A55A5A, 1'b0));
    cmd(SIRP_DEV_ADDR, 8'h03, 1'b1, 32'h0);
    chk(64'(d), 64'h0);
    $display("test locked write done");
    cmd(SIRP_DEV_ADDR, SIRP_SLEEP_REG, 1'b0, 32'h12345678);
    chk(64'(sleep_word), 64'h12345678);
    cmd(SIRP_DEV_ADDR, SIRP_SLEEP_REG, 1'b1, 32'h0);
    chk(64'(d), 64'h12345678);
    chk(64'(nbit), 64'd46);
    chk(64'(mon[45:1]), frm(RA, 32'h12345678, 1'b1));
    $display("test sleep register done");
    cmd(SIRP_DEV_ADDR, SIRP_UNLOCK_REG, 1'b0, 32'h2C413535);
    chk(64'(unlocked), 64'h0);
    cmd(SIRP_DEV_ADDR, SIRP_UNLOCK_REG, 1'b0, SIRP_UNLOCK_CODE);
    chk(64'(unlocked), 64'h1);
    cmd(SIRP_DEV_ADDR, 8'h03, 1'b0, 32'hDEADBEEF);
    cmd(SIRP_DEV_ADDR, 8'h04, 1'b0, 32'h01020304);
    cmd(SIRP_DEV_ADDR, 8'h03, 1'b1, 32'h0);
    chk(64'(d), 64'hDEADBEEF);
    cmd(SIRP_DEV_ADDR, 8'h04, 1'b1, 32'h0);
    chk(64'(d), 64'h01020304);
    $display("test unlock done");
    cmd(7'h61, 8'h03, 1'b0, 32'h55555555);
    chk(64'(st[SIRP_STAT_NACK]), 64'h1);
    chk(64'(nbit), 64'd10);
    cmd(SIRP_DEV_ADDR, 8'h03, 1'b1, 32'h0);
    chk(64'(d), 64'hDEADBEEF);
    chk(64'(unlocked), 64'h1);
    $display("test foreign address done");
    axw(8'h10, 32'h0, r);
    chk(64'(r), 64'(SIRP_RESP_ERR));
    axr(8'h14, d, r);
    chk(64'(r), 64'(SIRP_RESP_ERR));
    chk(64'(d), 64'h0);
    // Byte strobes on the data register, command fields read back
    wstrb <= 4'h3;
    axw(SIRP_WDATA_OFS, 32'hFFFFFFFF, r);
    wstrb <= 4'hF;
    axr(SIRP_WDATA_OFS, d, r);
    chk(64'(d), 64'h0000FFFF);
    axr(SIRP_CTRL_OFS, d, r);
    chk(64'(d), 64'({15'h0, 1'b1, 8'h03, 1'b0, SIRP_DEV_ADDR}));
    $display("test unmapped access done");
    rst();
    chk(64'(unlocked), 64'h0);
    cmd(SIRP_DEV_ADDR, 8'h03, 1'b1, 32'h0);
    chk(64'(d), 64'(SIRP_REG_RST));
    $display("test second reset done");
    stop_test();
  end
endmodule : tb_sensor_i2c_register_port

// ===== verilog/sirp_ctrl.sv
/*
 * Controller end: AXI4-Lite register slave that runs one register write
 * or one single-register read on the two-wire bus per command.
 * Assumes the target answers within each SCL quarter period.
 */
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module sirp_ctrl
  import sirp_pkg::*;
#(
  parameter int QTR = SIRP_QTR_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  sirp_if.ctl              bus,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum logic [1:0] {C_IDLE, C_START, C_BYTE, C_STOP} sirp_cst_t;

  typedef struct packed {
    logic [2:0]  sda_s;
    logic        sda_f;
    sirp_cst_t   st;
    logic [1:0]  q;
    logic [15:0] tk;
    logic [3:0]  bitn;
    logic [2:0]  step;
    logic [7:0]  sh;
    logic        scl_oe;
    logic        sda_oe;
    logic [6:0]  dev;
    logic [7:0]  rg;
    logic        rd_op;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        busy;
    logic        nack;
    logic        aw_ok;
    logic [7:0]  awa;
    logic        w_ok;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  bresp;
    logic        rv;
    logic [31:0] rdd;
    logic [1:0]  rresp;
  } sirp_cstate_t;

  sirp_cstate_t c_r;
  sirp_cstate_t c_nxt;

  // Byte sent in a given step of the command
  function automatic logic [7:0] sirp_tx(input logic [2:0] s);
    case (s)
      3'h0:    sirp_tx = {c_r.dev, 1'b0};
      3'h1:    sirp_tx = c_r.rg;
      3'h2:    sirp_tx = c_r.rd_op ? {c_r.dev, 1'b1} : c_r.wdat[31:24];
      3'h3:    sirp_tx = c_r.wdat[23:16];
      3'h4:    sirp_tx = c_r.wdat[15:8];
      3'h5:    sirp_tx = c_r.wdat[7:0];
      default: sirp_tx = 8'hFF;
    endcase
  endfunction : sirp_tx

  // Bus slave and serial sequencer
  always_comb begin
    logic tick;
    logic rx;
    logic last;
    tick  = 1'b0;
    rx    = 1'b0;
    last  = 1'b0;
    c_nxt = c_r;
    c_nxt.sda_s = {c_r.sda_s[1:0], bus.sda};
    if (c_r.sda_s[1] == c_r.sda_s[2]) begin
      c_nxt.sda_f = c_r.sda_s[2];
    end
    // Write channel: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      c_nxt.aw_ok = 1'b1;
      c_nxt.awa   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      c_nxt.w_ok = 1'b1;
      c_nxt.wd   = s_axi_wdata;
      c_nxt.ws   = s_axi_wstrb;
    end
    if (c_r.bv && s_axi_bready) begin
      c_nxt.bv = 1'b0;
    end
    if (c_r.aw_ok && c_r.w_ok) begin
      c_nxt.aw_ok = 1'b0;
      c_nxt.w_ok  = 1'b0;
      c_nxt.bv    = 1'b1;
      c_nxt.bresp = c_r.awa[7:4] == 4'h0 ? SIRP_RESP_OK : SIRP_RESP_ERR;
      if ({c_r.awa[7:2], 2'h0} == SIRP_WDATA_OFS) begin
        for (int i = 0; i < 4; i++) begin
          if (c_r.ws[i]) begin
            c_nxt.wdat[8*i +: 8] = c_r.wd[8*i +: 8];
          end
        end
      end else if ({c_r.awa[7:2], 2'h0} == SIRP_CTRL_OFS
                   && c_r.wd[SIRP_CTRL_GO] && !c_r.busy) begin
        c_nxt.dev   = c_r.wd[SIRP_CTRL_DEV +: 7];
        c_nxt.rg    = c_r.wd[SIRP_CTRL_REG +: 8];
        c_nxt.rd_op = c_r.wd[SIRP_CTRL_RD];
        c_nxt.busy  = 1'b1;
        c_nxt.nack  = 1'b0;
        c_nxt.st    = C_START;
        c_nxt.q     = '0;
        c_nxt.tk    = '0;
        c_nxt.step  = '0;
      end
    end
    // Read channel
    if (c_r.rv && s_axi_rready) begin
      c_nxt.rv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      c_nxt.rv    = 1'b1;
      c_nxt.rresp = s_axi_araddr[7:4] == 4'h0 ? SIRP_RESP_OK : SIRP_RESP_ERR;
      case ({s_axi_araddr[7:2], 2'h0})
        SIRP_CTRL_OFS:  c_nxt.rdd = {15'h0, c_r.rd_op, c_r.rg, 1'b0, c_r.dev};
        SIRP_WDATA_OFS: c_nxt.rdd = c_r.wdat;
        SIRP_RDATA_OFS: c_nxt.rdd = c_r.rdat;
        SIRP_STAT_OFS:  c_nxt.rdd = {30'h0, c_r.nack, c_r.busy};
        default:        c_nxt.rdd = 32'h0000_0000;
      endcase
    end
    // Quarter-period enable for the serial clock
    if (c_r.st != C_IDLE) begin
      tick     = c_r.tk == 16'(QTR - 1);
      c_nxt.tk = tick ? 16'h0000 : c_r.tk + 16'h0001;
    end
    rx   = c_r.rd_op && c_r.step >= 3'h3;
    last = c_r.step == (c_r.rd_op ? 3'h6 : 3'h5);
    if (tick) begin
      c_nxt.q = c_r.q + 2'h1;
      case (c_r.st)
        C_START: begin
          case (c_r.q)
            2'h0: begin
              c_nxt.sda_oe = 1'b0;
              c_nxt.scl_oe = 1'b1;
            end
            2'h1: c_nxt.scl_oe = 1'b0;
            2'h2: c_nxt.sda_oe = 1'b1;
            default: begin
              c_nxt.scl_oe = 1'b1;
              c_nxt.st     = C_BYTE;
              c_nxt.bitn   = '0;
              c_nxt.sh     = sirp_tx(c_r.step);
            end
          endcase
        end
        C_BYTE: begin
          case (c_r.q)
            2'h0: begin
              if (c_r.bitn == 4'h8) begin
                c_nxt.sda_oe = rx && !last;
              end else begin
                c_nxt.sda_oe = !rx && !c_r.sh[7];
              end
            end
            2'h1: c_nxt.scl_oe = 1'b0;
            2'h2: begin
              if (rx && c_r.bitn != 4'h8) begin
                c_nxt.sh = {c_r.sh[6:0], c_r.sda_f};
              end else if (!rx && c_r.bitn == 4'h8 && c_r.sda_f) begin
                c_nxt.nack = 1'b1;
              end
            end
            default: begin
              c_nxt.scl_oe = 1'b1;
              c_nxt.bitn   = c_r.bitn + 4'h1;
              if (!rx && c_r.bitn != 4'h8) begin
                c_nxt.sh = {c_r.sh[6:0], 1'b0};
              end
              if (rx && c_r.bitn == 4'h7) begin
                c_nxt.rdat = {c_r.rdat[23:0], c_r.sh};
              end
              if (c_r.bitn == 4'h8) begin
                c_nxt.bitn = '0;
                if (c_nxt.nack || last) begin
                  c_nxt.st = C_STOP;
                end else if (c_r.rd_op && c_r.step == 3'h1) begin
                  c_nxt.st   = C_START;
                  c_nxt.step = 3'h2;
                end else begin
                  c_nxt.step = c_r.step + 3'h1;
                  c_nxt.sh   = sirp_tx(c_r.step + 3'h1);
                end
              end
            end
          endcase
        end
        C_STOP: begin
          case (c_r.q)
            2'h0: c_nxt.sda_oe = 1'b1;
            2'h1: c_nxt.scl_oe = 1'b0;
            2'h2: c_nxt.sda_oe = 1'b0;
            default: begin
              c_nxt.st   = C_IDLE;
              c_nxt.busy = 1'b0;
            end
          endcase
        end
        default: c_nxt.st = C_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c_r       <= '0;
      c_r.sda_s <= 3'h7;
      c_r.sda_f <= 1'b1;
      c_r.st    <= C_IDLE;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Pins and bus outputs
  assign bus.ctl_scl_o  = 1'b0;
  assign bus.ctl_scl_oe = c_r.scl_oe;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_sda_oe = c_r.sda_oe;
  assign s_axi_awready  = !c_r.aw_ok && !c_r.bv;
  assign s_axi_wready   = !c_r.w_ok && !c_r.bv;
  assign s_axi_bvalid   = c_r.bv;
  assign s_axi_bresp    = c_r.bresp;
  assign s_axi_arready  = !c_r.rv;
  assign s_axi_rvalid   = c_r.rv;
  assign s_axi_rdata    = c_r.rdd;
  assign s_axi_rresp    = c_r.rresp;
endmodule : sirp_ctrl

// ===== verilog/sirp_if.sv
/*
 * Two-wire bus between controller and sensor target.
 * Open-drain: an enable high pulls the line low; lines idle high.
 */
`timescale 1ns/10ps
interface sirp_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND line levels
  assign scl = !(ctl_scl_oe && !ctl_scl_o);
  assign sda = !(ctl_sda_oe && !ctl_sda_o) && !(tgt_sda_oe && !tgt_sda_o);

  modport ctl (output ctl_scl_o, ctl_scl_oe, ctl_sda_o, ctl_sda_oe,
               input scl, sda);
  modport tgt (output tgt_sda_o, tgt_sda_oe, input scl, sda);
endinterface : sirp_if

// ===== verilog/sirp_pkg.sv
/*
 * Shared constants of the sensor register port: target address, register
 * map of the sensor, controller register map and serial clock timing.
 * Assumes a 100 MHz system clock on both ends.
 */
package sirp_pkg;
  // Sensor side
  localparam logic [6:0]  SIRP_DEV_ADDR    = 7'h60;
  localparam int          SIRP_NREG        = 16;
  localparam logic [7:0]  SIRP_UNLOCK_REG  = 8'h35;
  localparam logic [31:0] SIRP_UNLOCK_CODE = 32'h2C413534;
  localparam logic [7:0]  SIRP_SLEEP_REG   = 8'h0E;
  localparam logic [31:0] SIRP_REG_RST     = 32'h0000_0000;
  // Controller register map (byte offsets)
  localparam logic [7:0]  SIRP_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  SIRP_WDATA_OFS   = 8'h04;
  localparam logic [7:0]  SIRP_RDATA_OFS   = 8'h08;
  localparam logic [7:0]  SIRP_STAT_OFS    = 8'h0C;
  localparam int          SIRP_CTRL_DEV    = 0;
  localparam int          SIRP_CTRL_REG    = 8;
  localparam int          SIRP_CTRL_RD     = 16;
  localparam int          SIRP_CTRL_GO     = 31;
  localparam int          SIRP_STAT_BUSY   = 0;
  localparam int          SIRP_STAT_NACK   = 1;
  localparam logic [1:0]  SIRP_RESP_OK     = 2'h0;
  localparam logic [1:0]  SIRP_RESP_ERR    = 2'h2;
  // Serial clock timing
  localparam int          SIRP_CLK_NS      = 10;
  localparam int          SIRP_SCL_NS      = 1000;
  localparam int          SIRP_QTR_CYC     = SIRP_SCL_NS / (4 * SIRP_CLK_NS);
endpackage : sirp_pkg

// ===== verilog/sirp_target.sv
/*
 * Sensor end of the register port: serial target with a small register
 * file, a write lock released by an access code, and a sleep register.
 * Assumes the controller drives SCL; both lines are sampled by clk.
 */
`timescale 1ns/10ps
//Contract
// - Target only, never drives clock or starts
// - SDA falling while SCL high is start
// - 7-bit address, direction bit, then acknowledge slot
// - SDA rising while SCL high is stop
// - SDA changes only while SCL low
// - Start or stop restarts the transfer sequence
// - Matching address acknowledged in ninth clock
// - Each written byte acknowledged by target
// - Controller releases SDA for acknowledge
// - Write: address, register, four bytes MSB first
// - Locked: writes ignored
// - Sleep register writable while locked
// - Reads always served
// - Code 0x2C413534 to 0x35 releases lock
// - Released lock stays until power cycle; the code clears it at any reset_n low
// - Read: register, restart, four bytes MSB first
// - Acknowledged fourth byte continues at next register
// - Not-acknowledge ends target data drive
// - One read covers consecutive registers only
module sirp_target
  import sirp_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = SIRP_DEV_ADDR,
  parameter int         NREG     = SIRP_NREG
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  sirp_if.tgt              bus,
  output logic             unlocked,
  output logic [31:0]      sleep_word
);
  localparam int IW = $clog2(NREG);

  typedef enum logic [2:0] {
    T_IDLE, T_ADDR, T_AACK, T_RX, T_RACK, T_TX, T_TACK, T_SKIP
  } sirp_tst_t;

  typedef struct packed {
    logic [2:0]                scl_s;
    logic [2:0]                sda_s;
    logic                      scl_f;
    logic                      sda_f;
    sirp_tst_t                 st;
    logic [3:0]                cnt;
    logic [7:0]                sh;
    logic                      rw;
    logic [2:0]                bidx;
    logic [7:0]                ptr;
    logic [31:0]               wd;
    logic                      sda_oe;
    logic                      unl;
    logic [NREG-1:0][31:0]     regs;
  } sirp_tstate_t;

  sirp_tstate_t r_r;
  sirp_tstate_t r_nxt;

  // Byte of a register as sent on a read, MSB byte first
  function automatic logic [7:0] sirp_byte(input logic [7:0] p,
                                           input logic [1:0] b);
    logic [31:0] w;
    w = '0;
    if (p < 8'(NREG)) begin
      w = r_r.regs[p[IW-1:0]];
    end
    sirp_byte = w[8*(3-b) +: 8];
  endfunction : sirp_byte

  // Line filtering, condition detection and byte sequencing
  always_comb begin
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic [31:0] word;
    logic [7:0]  np;
    logic [1:0]  nb;
    logic [7:0]  tb;
    rise  = 1'b0;
    fall  = 1'b0;
    start = 1'b0;
    stop  = 1'b0;
    word  = '0;
    np    = '0;
    nb    = '0;
    tb    = '0;
    r_nxt = r_r;
    r_nxt.scl_s = {r_r.scl_s[1:0], bus.scl};
    r_nxt.sda_s = {r_r.sda_s[1:0], bus.sda};
    if (r_r.scl_s[1] == r_r.scl_s[2]) begin
      r_nxt.scl_f = r_r.scl_s[2];
    end
    if (r_r.sda_s[1] == r_r.sda_s[2]) begin
      r_nxt.sda_f = r_r.sda_s[2];
    end
    rise  = !r_r.scl_f && r_nxt.scl_f;
    fall  = r_r.scl_f && !r_nxt.scl_f;
    start = r_r.scl_f && r_nxt.scl_f && r_r.sda_f && !r_nxt.sda_f;
    stop  = r_r.scl_f && r_nxt.scl_f && !r_r.sda_f && r_nxt.sda_f;
    if (start) begin
      r_nxt.st     = T_ADDR;
      r_nxt.cnt    = '0;
      r_nxt.sda_oe = 1'b0;
    end else if (stop) begin
      r_nxt.st     = T_IDLE;
      r_nxt.sda_oe = 1'b0;
    end else begin
      case (r_r.st)
        T_ADDR, T_RX: begin
          if (rise) begin
            r_nxt.sh  = {r_r.sh[6:0], r_nxt.sda_f};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (fall && r_r.cnt == 4'h8) begin
            if (r_r.st == T_ADDR) begin
              if (r_r.sh[7:1] == OWN_ADDR) begin
                r_nxt.rw     = r_r.sh[0];
                r_nxt.sda_oe = 1'b1;
                r_nxt.st     = T_AACK;
                if (!r_r.sh[0]) begin
                  r_nxt.bidx = '0;
                end
              end else begin
                r_nxt.st = T_SKIP;
              end
            end else begin
              r_nxt.sda_oe = 1'b1;
              r_nxt.st     = T_RACK;
              word = {r_r.wd[23:0], r_r.sh};
              if (r_r.bidx == 3'h0) begin
                r_nxt.ptr = r_r.sh;
              end else if (r_r.bidx <= 3'h4) begin
                r_nxt.wd = word;
              end
              if (r_r.bidx == 3'h4) begin
                if (r_r.ptr == SIRP_UNLOCK_REG
                    && word == SIRP_UNLOCK_CODE) begin
                  r_nxt.unl = 1'b1;
                end else if ((r_r.unl || r_r.ptr == SIRP_SLEEP_REG)
                             && r_r.ptr < 8'(NREG)) begin
                  r_nxt.regs[r_r.ptr[IW-1:0]] = word;
                end
              end
              if (r_r.bidx < 3'h5) begin
                r_nxt.bidx = r_r.bidx + 3'h1;
              end
            end
          end
        end
        T_AACK: begin
          if (fall) begin
            r_nxt.cnt = '0;
            if (r_r.rw) begin
              tb = sirp_byte(r_r.ptr, 2'h0);
              r_nxt.bidx   = '0;
              r_nxt.sh     = tb;
              r_nxt.sda_oe = !tb[7];
              r_nxt.st     = T_TX;
            end else begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st     = T_RX;
            end
          end
        end
        T_RACK: begin
          if (fall) begin
            r_nxt.sda_oe = 1'b0;
            r_nxt.cnt    = '0;
            r_nxt.st     = T_RX;
          end
        end
        T_TX: begin
          if (rise) begin
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (fall) begin
            if (r_r.cnt == 4'h8) begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st     = T_TACK;
            end else begin
              r_nxt.sh     = {r_r.sh[6:0], 1'b0};
              r_nxt.sda_oe = !r_r.sh[6];
            end
          end
        end
        T_TACK: begin
          if (rise && r_nxt.sda_f) begin
            r_nxt.st = T_SKIP;
          end else if (fall) begin
            np = r_r.ptr;
            nb = r_r.bidx[1:0] + 2'h1;
            if (r_r.bidx[1:0] == 2'h3) begin
              np = r_r.ptr + 8'h01;
            end
            tb = sirp_byte(np, nb);
            r_nxt.ptr    = np;
            r_nxt.bidx   = {1'b0, nb};
            r_nxt.sh     = tb;
            r_nxt.sda_oe = !tb[7];
            r_nxt.cnt    = '0;
            r_nxt.st     = T_TX;
          end
        end
        T_IDLE, T_SKIP: begin
          r_nxt.sda_oe = 1'b0;
        end
        default: begin
          r_nxt.st     = T_IDLE;
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; lock clears only at reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_r       <= '0;
      r_r.scl_s <= 3'h7;
      r_r.sda_s <= 3'h7;
      r_r.scl_f <= 1'b1;
      r_r.sda_f <= 1'b1;
      r_r.st    <= T_IDLE;
      r_r.regs  <= {NREG{SIRP_REG_RST}};
    end else begin
      r_r <= r_nxt;
    end
  end

  // Pins and user-side outputs
  assign bus.tgt_sda_o  = 1'b0;
  assign bus.tgt_sda_oe = r_r.sda_oe;
  assign unlocked       = r_r.unl;
  assign sleep_word     = r_r.regs[SIRP_SLEEP_REG[IW-1:0]];
endmodule : sirp_target
